//--- rtl/pcmc_top.sv
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
module pcmc_top (
    // Clock and reset.
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    // Wishbone classic slave.
    input  wire logic                              wb_cyc_i,
    input  wire logic                              wb_stb_i,
    input  wire logic                              wb_we_i,
    input  wire logic [3:0]                        wb_adr_i,
    input  wire logic [3:0]                        wb_sel_i,
    input  wire logic [31:0]                       wb_dat_i,
    output logic      [31:0]                       wb_dat_o,
    output logic                                   wb_ack_o,
    // System inputs.
    input  wire logic                              protected_write_enable_i,
    input  wire logic                              regulator_ready_i,
    input  wire logic                              ext_clock_alive_i,
    input  wire logic                              int_osc_one_alive_i,
    // Clock generator controls.
    output logic                                   cpu_tick_o,
    output logic      [pcmc_pkg::PCMC_MULT_W-1:0]  cpu_mult_o,
    output logic      [1:0]                        cpu_div_sel_o,
    output logic      [3:0]                        pll_mode_o,
    output logic                                   pll_powered_o,
    output logic                                   limp_mode_o,
    output logic                                   missing_reset_o,
    // Oscillator controls.
    output logic                                   osc_feed_block_o,
    output logic                                   crystal_osc_disable_o,
    output logic                                   ext_clock_input_disable_o,
    output logic                                   primary_source_select_o,
    output logic                                   secondary_source_select_o
);
    import pcmc_pkg::*;

    typedef struct packed {
        logic [4:0]  mult;
        logic [4:0]  applied_mult;
        logic [1:0]  applied_div;
        logic [1:0]  tick_cnt;
        logic        reg_gate_en;
        logic [1:0]  div_sel;
        logic        det_dis;
        logic        feed_blk;
        logic        pwr_off;
        logic        miss_flag;
        logic        lock_flag;
        logic [15:0] lock_prd;
        logic [15:0] lock_cnt;
        logic        xtal_dis;
        logic        xclk_dis;
        logic        prim_sel;
        logic        sec_sel;
        pcmc_mode_e  mode;
        logic        ack;
        logic [31:0] rdat;
        logic        miss_rst;
    } pcmc_state_s;

    pcmc_state_s q;
    pcmc_state_s n;
    logic        req;
    logic        wr;
    logic        relock;
    logic        ext_ok;
    logic        src2_miss;
    logic        src1_miss;
    logic        det_active;
    logic        pll_hold;
    logic [1:0]  last_phase;
    logic        tick;

    // Bus request decode; writes need the protection window open.
    assign req = wb_cyc_i & wb_stb_i & ~q.ack;
    assign wr  = req & wb_we_i & protected_write_enable_i;

    // External sources are usable only while they run and are not blocked.
    assign ext_ok    = ext_clock_alive_i & ~q.feed_blk;
    assign src2_miss = q.prim_sel & ~ext_ok &
                       (~q.sec_sel | ~(q.xtal_dis & q.xclk_dis));
    assign src1_miss  = ~q.prim_sel & ~int_osc_one_alive_i;
    assign det_active = ~q.det_dis & ~q.miss_flag;

    // Last phase of the current output period for the applied divider.
    always_comb begin
        case (q.applied_div)
            PCMC_DIV_BY2: last_phase = PCMC_LAST_BY2;
            PCMC_DIV_BY1: last_phase = PCMC_LAST_BY1;
            default:      last_phase = PCMC_LAST_BY4;
        endcase
    end
    assign tick = (q.tick_cnt == last_phase);

    // Next state of the whole block.
    always_comb begin
        n          = q;
        n.ack      = 1'b0;
        n.miss_rst = 1'b0;
        relock     = 1'b0;
        if (req) begin
            n.ack  = 1'b1;
            n.rdat = 32'h0000_0000;
            case (wb_adr_i)
                PCMC_ADR_MULT:   n.rdat[4:0] = q.mult;
                PCMC_ADR_STATUS: begin
                    n.rdat[PCMC_ST_REGGATE] = q.reg_gate_en;
                    n.rdat[PCMC_ST_DIV_HI:PCMC_ST_DIV_LO] = q.div_sel;
                    n.rdat[PCMC_ST_DETDIS]  = q.det_dis;
                    n.rdat[PCMC_ST_FEEDBLK] = q.feed_blk;
                    n.rdat[PCMC_ST_MFLAG]   = q.miss_flag;
                    n.rdat[PCMC_ST_PWROFF]  = q.pwr_off;
                    n.rdat[PCMC_ST_LOCK]    = q.lock_flag;
                end
                PCMC_ADR_LOCKP:  n.rdat[15:0] = q.lock_prd;
                PCMC_ADR_SRC:    begin
                    n.rdat[PCMC_SRC_XTALDIS] = q.xtal_dis;
                    n.rdat[PCMC_SRC_XCLKDIS] = q.xclk_dis;
                    n.rdat[PCMC_SRC_SEC]     = q.sec_sel;
                    n.rdat[PCMC_SRC_PRIM]    = q.prim_sel;
                end
                default:         n.rdat = 32'h0000_0000;
            endcase
        end
        // Multiplier writes; reserved codes leave the ratio untouched.
        if (wr && wb_adr_i == PCMC_ADR_MULT && wb_sel_i[0] &&
            wb_dat_i[4:0] <= PCMC_MULT_MAX) begin
            n.mult = wb_dat_i[4:0];
            relock = (wb_dat_i[4:0] != 5'h00);
        end
        // Status and control writes, lane by lane.
        if (wr && wb_adr_i == PCMC_ADR_STATUS) begin
            if (wb_sel_i[0]) begin
                n.div_sel[0] = wb_dat_i[PCMC_ST_DIV_LO];
                n.det_dis    = wb_dat_i[PCMC_ST_DETDIS];
                n.feed_blk   = wb_dat_i[PCMC_ST_FEEDBLK];
                n.pwr_off    = wb_dat_i[PCMC_ST_PWROFF];
                if (wb_dat_i[PCMC_ST_MCLR]) begin
                    n.miss_flag = 1'b0;
                end
            end
            if (wb_sel_i[1]) begin
                n.div_sel[1]  = wb_dat_i[PCMC_ST_DIV_HI];
                n.reg_gate_en = wb_dat_i[PCMC_ST_REGGATE];
            end
        end
        // Lock period writes.
        if (wr && wb_adr_i == PCMC_ADR_LOCKP) begin
            if (wb_sel_i[0]) begin
                n.lock_prd[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                n.lock_prd[15:8] = wb_dat_i[15:8];
            end
        end
        // Source control writes; a primary change zeroes the multiplier.
        if (wr && wb_adr_i == PCMC_ADR_SRC) begin
            if (wb_sel_i[0]) begin
                n.prim_sel = wb_dat_i[PCMC_SRC_PRIM];
                n.sec_sel  = wb_dat_i[PCMC_SRC_SEC];
                if (wb_dat_i[PCMC_SRC_PRIM] != q.prim_sel) begin
                    n.mult = 5'h00;
                    relock = 1'b0;
                end
            end
            if (wb_sel_i[1]) begin
                n.xtal_dis = wb_dat_i[PCMC_SRC_XTALDIS];
                n.xclk_dis = wb_dat_i[PCMC_SRC_XCLKDIS];
            end
        end
        // Secondary source lost: fall back to oscillator one without limp.
        if (det_active && src2_miss) begin
            n.prim_sel  = 1'b0;
            n.mult      = 5'h00;
            n.miss_flag = 1'b0;
            relock      = 1'b0;
        end
        // Oscillator one lost: raise limp mode; this set wins over a clear.
        if (det_active && src1_miss) begin
            n.miss_flag = 1'b1;
            n.miss_rst  = 1'b1;
        end
        // Generator mode sequencing.
        case (q.mode)
            PCMC_ST_LOCKING: begin
                if (q.lock_cnt == 16'h0000) begin
                    n.mode      = PCMC_ST_ENABLED;
                    n.lock_flag = 1'b1;
                end else begin
                    n.lock_cnt = q.lock_cnt - 16'h0001;
                end
            end
            PCMC_ST_ENABLED: n.mode = PCMC_ST_ENABLED;
            PCMC_ST_BYPASS:  n.mode = PCMC_ST_BYPASS;
            PCMC_ST_OFF:     begin
                n.mode      = PCMC_ST_LOCKING;
                n.lock_cnt  = q.lock_prd;
                n.lock_flag = 1'b0;
            end
            default:         n.mode = PCMC_ST_BYPASS;
        endcase
        if (relock) begin
            n.mode      = PCMC_ST_LOCKING;
            n.lock_cnt  = n.lock_prd;
            n.lock_flag = 1'b0;
        end
        if (n.mult == 5'h00) begin
            n.mode      = PCMC_ST_BYPASS;
            n.lock_flag = 1'b1;
        end
        // Power-off or an unready gated regulator holds the generator down.
        pll_hold = n.pwr_off | (n.reg_gate_en & ~regulator_ready_i);
        if (pll_hold) begin
            n.mode      = PCMC_ST_OFF;
            n.lock_flag = 1'b1;
        end
        // Output period counter; new settings are taken only at a boundary.
        if (tick) begin
            n.tick_cnt    = 2'h0;
            n.applied_div = q.div_sel;
            n.applied_mult = (q.mode == PCMC_ST_ENABLED) ? q.mult : 5'h00;
        end else begin
            n.tick_cnt = q.tick_cnt + 2'h1;
        end
    end

    // State register; only the external or watchdog reset reaches it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q             <= '0;
            q.mult        <= PCMC_MULT_RST;
            q.applied_div <= PCMC_DIV_RST;
            q.div_sel     <= PCMC_DIV_RST;
            q.lock_flag   <= PCMC_LOCK_RST;
            q.lock_prd    <= PCMC_LOCKP_RST;
            q.lock_cnt    <= PCMC_LOCKP_RST;
            q.mode        <= PCMC_ST_BYPASS;
        end else begin
            q <= n;
        end
    end

    // Output drive.
    assign wb_dat_o                  = q.rdat;
    assign wb_ack_o                  = q.ack;
    assign cpu_tick_o                = tick;
    assign cpu_mult_o                = q.applied_mult;
    assign cpu_div_sel_o             = q.applied_div;
    assign pll_mode_o                = q.mode;
    assign pll_powered_o             = (q.mode != PCMC_ST_OFF);
    assign limp_mode_o               = q.miss_flag & ~q.det_dis;
    assign missing_reset_o           = q.miss_rst;
    assign osc_feed_block_o          = q.feed_blk;
    assign crystal_osc_disable_o     = q.xtal_dis;
    assign ext_clock_input_disable_o = q.xclk_dis;
    assign primary_source_select_o   = q.prim_sel;
    assign secondary_source_select_o = q.sec_sel;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Reserved multiplier codes never reach the register.
    chk_reserved_mult_kept: assert property (
        (wr && wb_adr_i == PCMC_ADR_MULT && wb_sel_i[0] && wb_dat_i[4:0] > PCMC_MULT_MAX
         && !(det_active && src2_miss))
        |=> (q.mult == $past(q.mult)))
        else $error("reserved multiplier code was stored");

    // Unprotected writes leave the lock period alone.
    chk_protect_blocks_write: assert property (
        (req && wb_we_i && !protected_write_enable_i) |=> $stable(q.lock_prd))
        else $error("write took effect without protection window");

    // A valid non-zero multiplier write drops the lock flag and enters locking.
    chk_relock_start: assert property (
        (relock && !pll_hold) |=> (!q.lock_flag && q.mode == PCMC_ST_LOCKING))
        else $error("multiplier write did not start locking");

    // Lock completes one cycle after the count reaches zero.
    chk_lock_done: assert property (
        (q.mode == PCMC_ST_LOCKING && q.lock_cnt == 16'h0000 && !relock && !pll_hold
         && n.mult != 5'h00) |=> (q.lock_flag && q.mode == PCMC_ST_ENABLED))
        else $error("lock did not complete at zero count");

    // A primary source change leaves the multiplier at zero.
    chk_source_zeroes_mult: assert property (
        $changed(q.prim_sel) |-> (q.mult == 5'h00))
        else $error("source change kept a multiplier");

    // The clear bit always reads back as zero.
    chk_clear_reads_zero: assert property (
        (req && wb_adr_i == PCMC_ADR_STATUS) |=> (wb_ack_o && !wb_dat_o[PCMC_ST_MCLR]))
        else $error("clear bit read as one");

    // Power-off or an unready gated regulator holds the generator down.
    chk_hold_powers_off: assert property (
        (q.pwr_off || (q.reg_gate_en && !$past(regulator_ready_i))) |-> !pll_powered_o)
        else $error("generator powered while held off");

    // Limp mode never shows while detection is disabled.
    chk_no_limp_disabled: assert property (
        q.det_dis |-> !limp_mode_o)
        else $error("limp mode while detection disabled");

    // Disabled detection never raises a missing clock event.
    chk_no_event_disabled: assert property (
        q.det_dis |=> !missing_reset_o)
        else $error("missing clock event while detection disabled");

    // The applied divider changes only right after a period boundary.
    chk_div_at_boundary: assert property (
        $changed(q.applied_div) |-> ($past(tick) && q.tick_cnt == 2'h0))
        else $error("divider changed mid period");

    // Acknowledge is a single cycle pulse.
    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held two cycles");

endmodule // pcmc_top

//--- pkg/pcmc_pkg.sv
package pcmc_pkg;

    // Register byte addresses on the bus.
    localparam logic [3:0] PCMC_ADR_MULT   = 4'h0;
    localparam logic [3:0] PCMC_ADR_STATUS = 4'h4;
    localparam logic [3:0] PCMC_ADR_LOCKP  = 4'h8;
    localparam logic [3:0] PCMC_ADR_SRC    = 4'hC;

    // Multiplier field.
    localparam int         PCMC_MULT_W     = 5;
    localparam logic [4:0] PCMC_MULT_MAX   = 5'h12;
    localparam logic [4:0] PCMC_MULT_RST   = 5'h00;

    // Status and control field positions.
    localparam int PCMC_ST_REGGATE = 15;
    localparam int PCMC_ST_DIV_HI  = 8;
    localparam int PCMC_ST_DIV_LO  = 7;
    localparam int PCMC_ST_DETDIS  = 6;
    localparam int PCMC_ST_FEEDBLK = 5;
    localparam int PCMC_ST_MCLR    = 4;
    localparam int PCMC_ST_MFLAG   = 3;
    localparam int PCMC_ST_PWROFF  = 2;
    localparam int PCMC_ST_LOCK    = 0;

    // Clock source control field positions.
    localparam int PCMC_SRC_XTALDIS = 14;
    localparam int PCMC_SRC_XCLKDIS = 13;
    localparam int PCMC_SRC_SEC     = 1;
    localparam int PCMC_SRC_PRIM    = 0;

    // Values after reset.
    localparam logic [15:0] PCMC_LOCKP_RST = 16'hFFFF;
    localparam logic [1:0]  PCMC_DIV_RST   = 2'h0;
    localparam logic        PCMC_LOCK_RST  = 1'b1;

    // Divider select codes and the last phase of each output period.
    localparam logic [1:0] PCMC_DIV_BY2   = 2'h2;
    localparam logic [1:0] PCMC_DIV_BY1   = 2'h3;
    localparam logic [1:0] PCMC_LAST_BY4  = 2'h3;
    localparam logic [1:0] PCMC_LAST_BY2  = 2'h1;
    localparam logic [1:0] PCMC_LAST_BY1  = 2'h0;

    // Main clock generator modes.
    typedef enum logic [3:0] {
        PCMC_ST_BYPASS  = 4'h1,
        PCMC_ST_LOCKING = 4'h2,
        PCMC_ST_ENABLED = 4'h4,
        PCMC_ST_OFF     = 4'h8
    } pcmc_mode_e;

endpackage

//--- verif/pcmc_top_tb_top.sv
`timescale 1ns/10ps
module pcmc_top_tb_top;
    import pcmc_pkg::*;

    // Stimulus and observed signals.
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        pwe = 1'b1;
    logic        reg_ready = 1'b1;
    logic        ext_alive = 1'b1;
    logic        osc1_alive = 1'b1;
    logic        cpu_tick_o;
    logic [4:0]  cpu_mult_o;
    logic [1:0]  cpu_div_sel_o;
    logic [3:0]  pll_mode_o;
    logic        pll_powered_o;
    logic        limp_mode_o;
    logic        missing_reset_o;
    logic        osc_feed_block_o;
    logic        crystal_osc_disable_o;
    logic        ext_clock_input_disable_o;
    logic        primary_source_select_o;
    logic        secondary_source_select_o;
    int          n_fail = 0;
    int          check_count = 0;

    // The oscillator clock runs at 10 MHz.
    always #50 clk_i = ~clk_i;

    // The block under test, with every input driven by the bench.
    pcmc_top dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .protected_write_enable_i(pwe),
        .regulator_ready_i(reg_ready), .ext_clock_alive_i(ext_alive),
        .int_osc_one_alive_i(osc1_alive), .cpu_tick_o(cpu_tick_o), .cpu_mult_o(cpu_mult_o),
        .cpu_div_sel_o(cpu_div_sel_o), .pll_mode_o(pll_mode_o),
        .pll_powered_o(pll_powered_o), .limp_mode_o(limp_mode_o),
        .missing_reset_o(missing_reset_o), .osc_feed_block_o(osc_feed_block_o),
        .crystal_osc_disable_o(crystal_osc_disable_o),
        .ext_clock_input_disable_o(ext_clock_input_disable_o),
        .primary_source_select_o(primary_source_select_o),
        .secondary_source_select_o(secondary_source_select_o));

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled high.
    task automatic bus(input logic we, input logic [3:0] adr, input logic [15:0] dat,
                       output logic [15:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0, dat};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            n_fail++;
            end_sim();
        end
        rd = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    // Register write and checked register read.
    task automatic wr(input logic [3:0] adr, input logic [15:0] dat);
        logic [15:0] d;
        bus(1'b1, adr, dat, d);
    endtask
    task automatic rdchk(input string name, input logic [3:0] adr, input logic [15:0] exp);
        logic [15:0] d;
        bus(1'b0, adr, 16'h0, d);
        chk(name, {16'h0, d}, {16'h0, exp});
    endtask

    // Waits, bounded, for the generator to reach a mode.
    task automatic wait_mode(input logic [3:0] m);
        int n;
        for (n = 0; n < 40 && pll_mode_o !== m; n++) begin
            @(negedge clk_i);
        end
        chk("mode wait", {28'h0, pll_mode_o}, {28'h0, m});
        if (pll_mode_o !== m) begin
            end_sim();
        end
    endtask

    // Reset values of registers and mode.
    task automatic t_reset();
        rdchk("mult rst", PCMC_ADR_MULT, 16'h0000);
        rdchk("stat rst", PCMC_ADR_STATUS, 16'h0001);
        rdchk("lockp rst", PCMC_ADR_LOCKP, 16'hFFFF);
        chk("mode rst", {28'h0, pll_mode_o}, {28'h0, PCMC_ST_BYPASS});
        chk("powered rst", {31'h0, pll_powered_o}, 32'h1);
        $display("test reset done");
    endtask

    // Writes without protected write enable, then a lock with a short period.
    task automatic t_lock();
        @(posedge clk_i);
        pwe <= 1'b0;
        wr(PCMC_ADR_MULT, 16'h0005);
        rdchk("mult unprot", PCMC_ADR_MULT, 16'h0000);
        @(posedge clk_i);
        pwe <= 1'b1;
        wr(PCMC_ADR_LOCKP, 16'h0003);
        wr(PCMC_ADR_MULT, 16'h0005);
        @(negedge clk_i);
        chk("mode locking", {28'h0, pll_mode_o}, {28'h0, PCMC_ST_LOCKING});
        wait_mode(PCMC_ST_ENABLED);
        rdchk("lock flag", PCMC_ADR_STATUS, 16'h0001);
        repeat (8) @(negedge clk_i);
        chk("mult applied", {27'h0, cpu_mult_o}, 32'h5);
        wr(PCMC_ADR_MULT, 16'h0013);
        rdchk("mult reserved", PCMC_ADR_MULT, 16'h0005);
        chk("mode kept", {28'h0, pll_mode_o}, {28'h0, PCMC_ST_ENABLED});
        wr(PCMC_ADR_MULT, 16'h0012);
        rdchk("mult max", PCMC_ADR_MULT, 16'h0012);
        wait_mode(PCMC_ST_ENABLED);
        $display("test lock done");
    endtask

    // Every divider code, with clear and flag bits written alongside.
    task automatic t_div();
        int code;
        int n;
        int exp_n [4] = '{2, 2, 4, 8};
        for (code = 0; code < 4; code++) begin
            wr(PCMC_ADR_STATUS, 16'(code << 7) | 16'h0018);
            rdchk("stat div", PCMC_ADR_STATUS, 16'(code << 7) | 16'h0001);
            repeat (8) @(negedge clk_i);
            chk("div applied", {30'h0, cpu_div_sel_o}, 32'(code));
            n = 0;
            repeat (8) begin
                @(negedge clk_i);
                if (cpu_tick_o === 1'b1) n++;
            end
            chk("ticks in 8", 32'(n), 32'(exp_n[code]));
        end
        wr(PCMC_ADR_STATUS, 16'h0000);
        $display("test divider done");
    endtask

    // Fallback when oscillator two is chosen without disabling external sources.
    task automatic t_switch();
        @(posedge clk_i);
        ext_alive <= 1'b0;
        wr(PCMC_ADR_SRC, 16'h0003);
        repeat (4) @(negedge clk_i);
        rdchk("src fallback", PCMC_ADR_SRC, 16'h0002);
        rdchk("mult zeroed", PCMC_ADR_MULT, 16'h0000);
        rdchk("flag clear", PCMC_ADR_STATUS, 16'h0001);
        wr(PCMC_ADR_SRC, 16'h6000);
        wr(PCMC_ADR_SRC, 16'h6003);
        repeat (4) @(negedge clk_i);
        rdchk("src osc two", PCMC_ADR_SRC, 16'h6003);
        chk("src pins", {28'h0, crystal_osc_disable_o, ext_clock_input_disable_o,
            secondary_source_select_o, primary_source_select_o}, 32'hF);
        wr(PCMC_ADR_SRC, 16'h0000);
        @(posedge clk_i);
        ext_alive <= 1'b1;
        wr(PCMC_ADR_SRC, 16'h0001);
        rdchk("src external", PCMC_ADR_SRC, 16'h0001);
        wr(PCMC_ADR_STATUS, 16'h0020);
        repeat (4) @(negedge clk_i);
        chk("feed pin", {31'h0, osc_feed_block_o}, 32'h1);
        chk("feed fallback", {31'h0, primary_source_select_o}, 32'h0);
        wr(PCMC_ADR_STATUS, 16'h0000);
        $display("test switch done");
    endtask

    // Limp event on a lost oscillator one, clear, and disabled detection.
    task automatic t_limp();
        int n;
        @(posedge clk_i);
        osc1_alive <= 1'b0;
        for (n = 0; n < 20 && missing_reset_o !== 1'b1; n++) @(negedge clk_i);
        chk("missing reset", {31'h0, missing_reset_o}, 32'h1);
        if (missing_reset_o !== 1'b1) begin
            end_sim();
        end
        chk("limp", {31'h0, limp_mode_o}, 32'h1);
        rdchk("flag set", PCMC_ADR_STATUS, 16'h0009);
        wr(PCMC_ADR_STATUS, 16'h0010);
        rdchk("flag refired", PCMC_ADR_STATUS, 16'h0009);
        @(posedge clk_i);
        osc1_alive <= 1'b1;
        wr(PCMC_ADR_STATUS, 16'h0010);
        rdchk("flag cleared", PCMC_ADR_STATUS, 16'h0001);
        wr(PCMC_ADR_STATUS, 16'h0040);
        @(posedge clk_i);
        osc1_alive <= 1'b0;
        repeat (10) @(negedge clk_i);
        chk("no limp", {31'h0, limp_mode_o}, 32'h0);
        rdchk("detect off", PCMC_ADR_STATUS, 16'h0041);
        @(posedge clk_i);
        osc1_alive <= 1'b1;
        wr(PCMC_ADR_STATUS, 16'h0000);
        $display("test limp done");
    endtask

    // Power-off bit and regulator gating of the generator.
    task automatic t_off();
        wr(PCMC_ADR_STATUS, 16'h0004);
        wait_mode(PCMC_ST_OFF);
        chk("unpowered", {31'h0, pll_powered_o}, 32'h0);
        wr(PCMC_ADR_STATUS, 16'h0000);
        wait_mode(PCMC_ST_BYPASS);
        @(posedge clk_i);
        reg_ready <= 1'b0;
        repeat (4) @(negedge clk_i);
        chk("ready ignored", {28'h0, pll_mode_o}, {28'h0, PCMC_ST_BYPASS});
        wr(PCMC_ADR_STATUS, 16'h8000);
        wait_mode(PCMC_ST_OFF);
        @(posedge clk_i);
        reg_ready <= 1'b1;
        wait_mode(PCMC_ST_BYPASS);
        $display("test power off done");
    endtask

    // Main sequence: reset for 20 cycles, then each scenario.
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_lock();
        t_div();
        t_switch();
        t_limp();
        t_off();
        end_sim();
    end
endmodule // pcmc_top_tb_top
